// ==== rtl/pcg_ahb_slv.sv ====
`timescale 1ns/1ps
module pcg_ahb_slv
  import pcg_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  pcg_reg_if.slave         rif
);
  pcg_slv_state_t q;
  pcg_slv_state_t d;
  logic           acc;

  // nonseq or seq with the bus ready starts a transfer
  assign acc = i_hsel & i_htrans[1] & i_hready;

  // reads take one wait state so hrdata comes from a flop and sees a write just before
  always_comb begin
    d         = q;
    d.wr_pend = 1'b0;
    if (q.rd_wait) begin
      d.hrdata  = {24'h000000, rif.rdata};
      d.rd_wait = 1'b0;
      d.ready   = 1'b1;
    end
    if (acc) begin
      d.idx     = i_haddr[31:2];
      d.wr_pend = i_hwrite;
      d.rd_wait = ~i_hwrite;
      d.ready   = i_hwrite;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '{wr_pend: 1'b0, rd_wait: 1'b0, ready: 1'b1, idx: '0, hrdata: 32'h00000000};
    end else begin
      q <= d;
    end
  end

  assign rif.wr_en  = q.wr_pend;
  assign rif.idx    = q.idx;
  assign rif.wdata  = i_hwdata[7:0];
  assign o_hrdata    = q.hrdata;
  assign o_hreadyout = q.ready;
  assign o_hresp     = 1'b0; // always okay
endmodule

// ==== rtl/pcg_port.sv ====
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
// What this block does
// - direction 1 makes pins 7,6,1,0 outputs and pins 5..2 chip-select 7..4 outputs.
// - direction 0 makes the pin an input with its driver off.
// - direction register is write-only and reads back all ones.
// - direction register clears on reset and hardware standby.
// - software standby keeps direction contents, outputs keep driving.
// - port read of an output pin returns the stored data bit.
// - port read of an input pin returns the pin level.
// - data register clears on reset and hardware standby, kept in software standby.
// - pin 5 feeds dma request 3 under the listed channel 3 select codes.
// - pin functions are the same in every operating mode.
module pcg_port
  import pcg_pkg::*;
(
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  input  wire logic        I_HW_STANDBY,
  input  wire logic [7:0]  I_PORT_PIN,
  output logic      [7:0]  O_PORT_OUT,
  output logic      [7:0]  O_PORT_OE,
  input  wire logic [3:0]  I_CHIP_SELECT_LINE_N,
  output logic             O_EXT_INTERRUPT_LINE_7_N,
  output logic             O_EXT_INTERRUPT_LINE_6_N,
  output logic             O_DMA_REQUEST_LINE_3_N
);
  pcg_reg_if       rif ();
  pcg_port_state_t q;
  pcg_port_state_t d;
  logic [8:0]      sync_o;
  logic [7:0]      pin_lvl;
  logic            hw_stby;
  logic            dreq_sel;
  logic            src_both;

  pcg_ahb_slv u_slv (
    .i_clk       (I_CORE_CLK),
    .i_rst       (I_RST),
    .i_hsel      (I_HSEL),
    .i_haddr     (I_HADDR),
    .i_htrans    (I_HTRANS),
    .i_hwrite    (I_HWRITE),
    .i_hwdata    (I_HWDATA),
    .i_hready    (I_HREADY),
    .o_hrdata    (O_HRDATA),
    .o_hreadyout (O_HREADYOUT),
    .o_hresp     (O_HRESP),
    .rif         (rif.slave)
  );

  // pins and the standby strap come from outside the clock domain
  pcg_sync #(.W(9)) u_sync (
    .i_clk   (I_CORE_CLK),
    .i_rst   (I_RST),
    .i_async ({I_HW_STANDBY, I_PORT_PIN}),
    .o_sync  (sync_o)
  );
  assign pin_lvl = sync_o[7:0];
  assign hw_stby = sync_o[8];

  // register writes; only full words are issued, hsize is not decoded
  always_comb begin
    d = q;
    if (rif.wr_en) begin
      unique case (rif.idx)
        PORT_DIRECTION_SELECT_IDX: d.dir   = rif.wdata;
        PORT_OUTPUT_DATA_IDX:      d.data  = rif.wdata;
        DMA_CH3_CONTROL_A_IDX:     d.dma_a = rif.wdata;
        DMA_CH3_CONTROL_B_IDX:     d.dma_b = rif.wdata;
        default:   d       = q;
      endcase
    end
  end

  // software standby has no input here: nothing clears, so contents hold
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || hw_stby) begin
      q <= '{dir: DIR_RST, data: DATA_RST, dma_a: DMA_RST, dma_b: DMA_RST};
    end else begin
      q <= d;
    end
  end

  // read mux; unmapped words read zero
  always_comb begin
    unique case (rif.idx)
      PORT_DIRECTION_SELECT_IDX: rif.rdata = DIR_READ;
      PORT_OUTPUT_DATA_IDX:      rif.rdata = (q.dir & q.data) | (~q.dir & pin_lvl);
      DMA_CH3_CONTROL_A_IDX:     rif.rdata = q.dma_a;
      DMA_CH3_CONTROL_B_IDX:     rif.rdata = q.dma_b;
      default:   rif.rdata = ZERO_BYTE;
    endcase
  end

  // pin drive; no mode input exists, so every mode sees the same mapping
  always_comb begin
    O_PORT_OE  = q.dir;
    O_PORT_OUT = q.data;
    for (int i = CS_LO_PIN; i <= CS_HI_PIN; i++) begin
      if (q.dir[i]) begin
        O_PORT_OUT[i] = I_CHIP_SELECT_LINE_N[i-CS_LO_PIN];
      end
    end
  end

  // interrupt lines follow the pin level whatever the direction
  assign O_EXT_INTERRUPT_LINE_7_N = pin_lvl[EXT_INT7_PIN];
  assign O_EXT_INTERRUPT_LINE_6_N = pin_lvl[EXT_INT6_PIN];

  // dma request only while pin 5 is an input; idle level is high
  assign src_both = q.dma_a[SEL_BIT2] & q.dma_a[SEL_BIT1];
  assign dreq_sel = (~src_both & q.dma_b[SEL_BIT2] & q.dma_b[SEL_BIT1])
                  | (src_both & ~q.dma_a[SEL_BIT0] & q.dma_b[SEL_BIT2])
                  | (src_both & q.dma_a[SEL_BIT0] & q.dma_b[SEL_BIT2] & q.dma_b[SEL_BIT1]);
  assign O_DMA_REQUEST_LINE_3_N = (dreq_sel & ~q.dir[DMA_REQ3_PIN]) ? pin_lvl[DMA_REQ3_PIN] : 1'b1;
endmodule

// ==== rtl/pcg_sync.sv ====
`timescale 1ns/1ps
module pcg_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pcg_sync_state_t;

  pcg_sync_state_t q;
  pcg_sync_state_t d;

  if (W < 1) begin : g_chk
    $error("pcg_sync width must be at least one");
  end

  // first stage feeds only the second stage
  always_comb begin
    d.s1 = i_async;
    d.s2 = q.s1;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.s2;
endmodule

// ==== shared/pcg_pkg.sv ====
package pcg_pkg;
  // word index of each register; byte address is four times the index
  localparam int unsigned IDX_W = 30;
  localparam logic [IDX_W-1:0] PORT_DIRECTION_SELECT_IDX = 30'h0000FFD5;
  localparam logic [IDX_W-1:0] PORT_OUTPUT_DATA_IDX      = 30'h0000FFD7;
  localparam logic [IDX_W-1:0] DMA_CH3_CONTROL_A_IDX     = 30'h0000FF00;
  localparam logic [IDX_W-1:0] DMA_CH3_CONTROL_B_IDX     = 30'h0000FF01;

  localparam int unsigned PORT_W = 8;

  // reset and read-back values
  localparam logic [7:0] DIR_RST   = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam logic [7:0] DMA_RST   = 8'h00;
  localparam logic [7:0] DIR_READ  = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // pin positions
  localparam int unsigned CS_LO_PIN  = 2;
  localparam int unsigned CS_HI_PIN  = 5;
  localparam int unsigned EXT_INT6_PIN = 6;
  localparam int unsigned EXT_INT7_PIN = 7;
  localparam int unsigned DMA_REQ3_PIN = 5;

  // transfer-select field positions in the channel 3 control copies
  localparam int unsigned SEL_BIT0 = 0;
  localparam int unsigned SEL_BIT1 = 1;
  localparam int unsigned SEL_BIT2 = 2;

  // bus slave state
  typedef struct packed {
    logic             wr_pend;
    logic             rd_wait;
    logic             ready;
    logic [IDX_W-1:0] idx;
    logic [31:0]      hrdata;
  } pcg_slv_state_t;

  // port register state
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] data;
    logic [7:0] dma_a;
    logic [7:0] dma_b;
  } pcg_port_state_t;
endpackage

// ==== shared/pcg_reg_if.sv ====
`timescale 1ns/1ps
interface pcg_reg_if;
  import pcg_pkg::*;
  logic             wr_en;
  logic [IDX_W-1:0] idx;
  logic [7:0]       wdata;
  logic [7:0]       rdata;

  modport slave (output wr_en, output idx, output wdata, input rdata);
  modport regs  (input wr_en, input idx, input wdata, output rdata);
endinterface

// ==== tb/pcg_pin_board.sv ====
`timescale 1ns/1ps
// board logic: drives its own level wherever the port's driver is off
module pcg_pin_board (
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_level,
  output logic      [7:0] o_pin
);
  // the port wins where it drives, so no pin ever floats
  assign o_pin = (i_oe & i_out) | (~i_oe & i_level);
endmodule

// ==== tb/pcg_port_asserts.sv ====
`timescale 1ns/1ps
module pcg_port_asserts (
  input  wire logic       I_CORE_CLK,
  input  wire logic       I_RST,
  input  wire logic       I_HSEL,
  input  wire logic [1:0] I_HTRANS,
  input  wire logic       I_HWRITE,
  input  wire logic       I_HREADY,
  input  wire logic       O_HREADYOUT,
  input  wire logic       O_HRESP,
  input  wire logic       I_HW_STANDBY,
  input  wire logic [7:0] I_PORT_PIN,
  input  wire logic [7:0] O_PORT_OUT,
  input  wire logic [7:0] O_PORT_OE,
  input  wire logic [3:0] I_CHIP_SELECT_LINE_N,
  input  wire logic       O_EXT_INTERRUPT_LINE_7_N,
  input  wire logic       O_EXT_INTERRUPT_LINE_6_N,
  input  wire logic       O_DMA_REQUEST_LINE_3_N
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  cs_top_a: assert property (O_PORT_OE[5] |-> O_PORT_OUT[5] == I_CHIP_SELECT_LINE_N[3])
    else $error("pin 5 not carrying chip select 7");
  cs_low_a: assert property (O_PORT_OE[2] |-> O_PORT_OUT[2] == I_CHIP_SELECT_LINE_N[0])
    else $error("pin 2 not carrying chip select 4");
  dreq_gate_a: assert property (O_PORT_OE[5] && $past(O_PORT_OE[5]) |-> O_DMA_REQUEST_LINE_3_N)
    else $error("dma request active on an output pin");
  reset_clear_a: assert property ($fell(I_RST) |-> O_PORT_OE == 8'h00 && O_PORT_OUT == 8'h00)
    else $error("port not cleared by reset");
  standby_clear_a: assert property (I_HW_STANDBY [*4] |-> O_PORT_OE == 8'h00 && O_PORT_OUT == 8'h00)
    else $error("port not cleared in hardware standby");
  irq_follow_a: assert property (!$past(I_RST) && !$past(I_RST, 2) |->
    {O_EXT_INTERRUPT_LINE_7_N, O_EXT_INTERRUPT_LINE_6_N} == $past(I_PORT_PIN[7:6], 2))
    else $error("interrupt lines not following pins 7 and 6");
  read_wait_a: assert property (I_HSEL && I_HTRANS[1] && I_HREADY && !I_HWRITE |=> !O_HREADYOUT ##1 O_HREADYOUT)
    else $error("read data phase not two cycles");
  write_fast_a: assert property (I_HSEL && I_HTRANS[1] && I_HREADY && I_HWRITE |=> O_HREADYOUT)
    else $error("write data phase stalled");
  resp_okay_a: assert property (!O_HRESP)
    else $error("error response on the register bus");
endmodule

// ==== tb/pcg_port_tb.sv ====
`timescale 1ns/1ps
module pcg_port_tb;
  import pcg_pkg::*;
  localparam logic [31:0] DIR_A = {PORT_DIRECTION_SELECT_IDX, 2'b00};
  localparam logic [31:0] DAT_A = {PORT_OUTPUT_DATA_IDX, 2'b00};
  logic        clk    = 1'b0;
  logic        rst    = 1'b1;
  logic        hsel   = 1'b0;
  logic        hwrite = 1'b0;
  logic        hws    = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr  = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0]  board  = 8'h5A;
  logic [3:0]  cs_n   = 4'hF;
  logic [31:0] hrdata, rd;
  logic [7:0]  pin, pout, poe;
  logic        hready, ext7_n, ext6_n, dreq_n;
  int          fails = 0, checked = 0, cyc = 0;

  pcg_port u_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(), .I_HW_STANDBY(hws), .I_PORT_PIN(pin), .O_PORT_OUT(pout),
    .O_PORT_OE(poe), .I_CHIP_SELECT_LINE_N(cs_n), .O_EXT_INTERRUPT_LINE_7_N(ext7_n),
    .O_EXT_INTERRUPT_LINE_6_N(ext6_n), .O_DMA_REQUEST_LINE_3_N(dreq_n));
  pcg_pin_board u_board (.i_oe(poe), .i_out(pout), .i_level(board), .o_pin(pin));

  // clock, plus a cycle ceiling so a stuck handshake cannot hang the run
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // hready is looked at mid-cycle, so the edge that follows is the one that samples it
  task automatic wait_rdy;
    @(negedge clk);
    while (hready !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic print_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    idle(3);
    chk("oe", 32'h0, {24'h0, poe});
    bus(DIR_A, 1'b0, 32'h0);
    chk("dir read", 32'hFF, rd);
    bus(DAT_A, 1'b0, 32'h0);
    chk("pin read", 32'h5A, rd);
    chk("irq", 32'h1, {30'h0, ext7_n, ext6_n});
    bus(DIR_A, 1'b1, 32'hC3);
    bus(DAT_A, 1'b1, 32'hFFFFFFB1);
    bus(DAT_A, 1'b0, 32'h0);
    chk("mixed read", 32'h99, rd);
    chk("oe", 32'hC3, {24'h0, poe});
    chk("out", 32'h81, {24'h0, pout & 8'hC3});
    bus(DIR_A, 1'b0, 32'h0);
    chk("dir read", 32'hFF, rd);
    idle(3);
    chk("irq", 32'h2, {30'h0, ext7_n, ext6_n});
    bus(32'h100, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(DIR_A, 1'b1, 32'hFF);
    cs_n <= 4'h6;
    idle(2);
    chk("cs out", 32'h99, {24'h0, pout});
    bus(DIR_A, 1'b1, 32'h0);
    // every select code, pin 5 held low by the board
    for (int c = 0; c < 32; c++) begin
      bus({DMA_CH3_CONTROL_A_IDX, 2'b00}, 1'b1, {29'h0, c[4:2]});
      bus({DMA_CH3_CONTROL_B_IDX, 2'b00}, 1'b1, {29'h0, c[1:0], 1'b0});
      idle(3);
      chk("dreq", {31'h0, !((!(c[4] && c[3]) && c[1] && c[0]) || (c[4] && c[3] && !c[2] && c[1])
        || (c[4] && c[3] && c[2] && c[1] && c[0]))}, {31'h0, dreq_n});
    end
    // last code matches: a high pin 5 must show, so the request is not a constant
    @(posedge clk);
    board <= 8'h7A;
    idle(3);
    chk("dreq pin", 32'h1, {31'h0, dreq_n});
    bus(DIR_A, 1'b1, 32'hFF);
    // pin 5 now carries a low chip select 7, yet the request must stay idle
    idle(3);
    chk("dreq gated", 32'h1, {31'h0, dreq_n});
    @(posedge clk);
    hws <= 1'b1;
    idle(5);
    chk("standby oe", 32'h0, {24'h0, poe});
    @(posedge clk);
    hws <= 1'b0;
    idle(3);
    bus(DIR_A, 1'b1, 32'hFF);
    idle(1);
    chk("standby data", 32'h18, {24'h0, pout});
    print_verdict();
  end
endmodule

bind pcg_port pcg_port_asserts u_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_HSEL(I_HSEL),
  .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .O_HREADYOUT(O_HREADYOUT),
  .O_HRESP(O_HRESP),
  .I_HW_STANDBY(I_HW_STANDBY), .I_PORT_PIN(I_PORT_PIN), .O_PORT_OUT(O_PORT_OUT), .O_PORT_OE(O_PORT_OE),
  .I_CHIP_SELECT_LINE_N(I_CHIP_SELECT_LINE_N), .O_EXT_INTERRUPT_LINE_7_N(O_EXT_INTERRUPT_LINE_7_N),
  .O_EXT_INTERRUPT_LINE_6_N(O_EXT_INTERRUPT_LINE_6_N), .O_DMA_REQUEST_LINE_3_N(O_DMA_REQUEST_LINE_3_N));
